// ---- logic/mem_incdec_defines.svh ----
// Behaviour
// - decrement in place: read byte, subtract one, write back same address
// - decrement to accumulator: byte minus one goes to accumulator, not memory
// - increment in place: read byte, add one, write back same address
// - increment to accumulator: byte plus one goes to accumulator, not memory
// - accumulator variants never write data memory
// - both decrements update zero flag only, other flags untouched
// - increment in place updates zero flag only, carry and others kept
`ifndef MEM_INCDEC_DEFINES_SVH
`define MEM_INCDEC_DEFINES_SVH
`define DATA_W        8
`define ADDR_W        8
`define STATUS_W      8
`define ZERO_BIT      2
`define ACC_RESET     8'h00
`define STATUS_RESET  8'h00
`define STEP_ONE      8'h01
`endif

// ---- logic/mem_incdec_pkg.sv ----
package mem_incdec_pkg;
  typedef enum logic [1:0] {
    OP_LONG_DECREMENT_MEMORY         = 2'b00,
    OP_LONG_DECREMENT_TO_ACCUMULATOR = 2'b01,
    OP_LONG_INCREMENT_MEMORY         = 2'b10,
    OP_LONG_INCREMENT_TO_ACCUMULATOR = 2'b11
  } op_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WB    = 2'b10
  } state_e;
endpackage

// ---- logic/incdec_alu.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mem_incdec_defines.svh"
module incdec_alu #(
  parameter int W = `DATA_W
) (
  // operand
  input  wire logic [W-1:0] i_operand,
  input  wire logic         i_decrement,
  // result
  output logic      [W-1:0] o_result,
  output logic              o_zero
);
  // wraps modulo two to the width
  always_comb begin
    if (i_decrement) begin
      o_result = i_operand - W'(`STEP_ONE);
    end else begin
      o_result = i_operand + W'(`STEP_ONE);
    end
    o_zero = (o_result == '0);
  end
endmodule
`default_nettype wire

// ---- logic/mem_incdec_datapath.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mem_incdec_defines.svh"
module mem_incdec_datapath #(
  parameter int DW = `DATA_W,
  parameter int AW = `ADDR_W
) (
  // clock and reset
  input  wire logic                 I_REF_CLK,
  input  wire logic                 I_RESET_N,
  // instruction from decoder
  input  wire logic                 I_START,
  input  wire logic [1:0]           I_OP,
  input  wire logic [AW-1:0]        I_ADDR,
  // data memory port
  output logic                      O_MEM_RD,
  output logic                      O_MEM_WR,
  output logic      [AW-1:0]        O_MEM_ADDR,
  output logic      [DW-1:0]        O_MEM_WDATA,
  input  wire logic [DW-1:0]        I_MEM_RDATA,
  // architectural state
  output logic      [DW-1:0]        O_ACCUMULATOR,
  output logic      [`STATUS_W-1:0] O_STATUS,
  output logic                      O_BUSY,
  output logic                      O_DONE
);
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  mem_incdec_pkg::state_e state_q, state_d;
  mem_incdec_pkg::op_e    op_q, op_d;
  logic [AW-1:0]          addr_q, addr_d;
  logic [DW-1:0]          acc_q, acc_d;
  logic [`STATUS_W-1:0]   status_q, status_d;
  logic [DW-1:0]          wdata_q, wdata_d;
  logic                   wr_q, wr_d;
  logic                   done_q, done_d;
  logic [DW-1:0]          result;
  logic                   zero;
  logic                   is_dec;
  logic                   to_acc;

  assign is_dec = (op_q == mem_incdec_pkg::OP_LONG_DECREMENT_MEMORY) ||
                  (op_q == mem_incdec_pkg::OP_LONG_DECREMENT_TO_ACCUMULATOR);
  assign to_acc = (op_q == mem_incdec_pkg::OP_LONG_DECREMENT_TO_ACCUMULATOR) ||
                  (op_q == mem_incdec_pkg::OP_LONG_INCREMENT_TO_ACCUMULATOR);

  incdec_alu #(
    .W (DW)
  ) u_alu (
    .i_operand   (I_MEM_RDATA),
    .i_decrement (is_dec),
    .o_result    (result),
    .o_zero      (zero)
  );

  always_comb begin
    state_d  = state_q;
    op_d     = op_q;
    addr_d   = addr_q;
    acc_d    = acc_q;
    status_d = status_q;
    wdata_d  = wdata_q;
    wr_d     = 1'b0;
    done_d   = 1'b0;
    case (state_q)
      mem_incdec_pkg::ST_IDLE: begin
        // start ignored while busy, decoder must wait for done
        if (I_START) begin
          op_d    = mem_incdec_pkg::op_e'(I_OP);
          addr_d  = I_ADDR;
          state_d = mem_incdec_pkg::ST_READ;
        end
      end
      mem_incdec_pkg::ST_READ: begin
        // memory answers read data in the cycle the read strobe is high
        status_d[`ZERO_BIT] = zero;
        if (to_acc) begin
          acc_d   = result;
          done_d  = 1'b1;
          state_d = mem_incdec_pkg::ST_IDLE;
        end else begin
          wdata_d = result;
          wr_d    = 1'b1;
          state_d = mem_incdec_pkg::ST_WB;
        end
      end
      mem_incdec_pkg::ST_WB: begin
        done_d  = 1'b1;
        state_d = mem_incdec_pkg::ST_IDLE;
      end
      default: begin
        state_d = mem_incdec_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q  <= mem_incdec_pkg::ST_IDLE;
      op_q     <= mem_incdec_pkg::OP_LONG_DECREMENT_MEMORY;
      addr_q   <= '0;
      acc_q    <= `ACC_RESET;
      status_q <= `STATUS_RESET;
      wdata_q  <= '0;
      wr_q     <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      op_q     <= op_d;
      addr_q   <= addr_d;
      acc_q    <= acc_d;
      status_q <= status_d;
      wdata_q  <= wdata_d;
      wr_q     <= wr_d;
      done_q   <= done_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign O_MEM_RD      = (state_q == mem_incdec_pkg::ST_READ);
  assign O_MEM_WR      = wr_q;
  assign O_MEM_ADDR    = addr_q;
  assign O_MEM_WDATA   = wdata_q;
  assign O_ACCUMULATOR = acc_q;
  assign O_STATUS      = status_q;
  assign O_BUSY        = (state_q != mem_incdec_pkg::ST_IDLE);
  assign O_DONE        = done_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  wb_value_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && op_q == mem_incdec_pkg::OP_LONG_DECREMENT_MEMORY) |=>
      (O_MEM_WR && O_MEM_WDATA == DW'($past(I_MEM_RDATA) - 1'b1)))
    else $error("decrement write-back value wrong");
  acc_dec_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && op_q == mem_incdec_pkg::OP_LONG_DECREMENT_TO_ACCUMULATOR) |=>
      (O_ACCUMULATOR == DW'($past(I_MEM_RDATA) - 1'b1)))
    else $error("decrement to accumulator wrong");
  inc_wb_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && op_q == mem_incdec_pkg::OP_LONG_INCREMENT_MEMORY) |=>
      (O_MEM_WR && O_MEM_WDATA == DW'($past(I_MEM_RDATA) + 1'b1) && $stable(O_MEM_ADDR)))
    else $error("increment write-back wrong");
  acc_inc_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && op_q == mem_incdec_pkg::OP_LONG_INCREMENT_TO_ACCUMULATOR) |=>
      (O_ACCUMULATOR == DW'($past(I_MEM_RDATA) + 1'b1) && O_DONE))
    else $error("increment to accumulator wrong");
  no_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && to_acc) |=> !O_MEM_WR [*2])
    else $error("memory written by accumulator variant");
  dec_flags_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && is_dec) |=>
      ((O_STATUS & ~(`STATUS_W'(1) << `ZERO_BIT)) ==
       ($past(O_STATUS) & ~(`STATUS_W'(1) << `ZERO_BIT))))
    else $error("decrement touched other flags");
  inc_flags_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (O_MEM_RD && !is_dec) |=>
      ((O_STATUS & ~(`STATUS_W'(1) << `ZERO_BIT)) ==
       ($past(O_STATUS) & ~(`STATUS_W'(1) << `ZERO_BIT))))
    else $error("increment touched other flags");
  zero_flag_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_MEM_RD |=> (O_STATUS[`ZERO_BIT] ==
      (is_dec ? ($past(I_MEM_RDATA) == DW'(1)) : ($past(I_MEM_RDATA) == '1))))
    else $error("zero flag wrong");
  done_bound_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (I_START && !O_BUSY) |=> ##[1:2] O_DONE)
    else $error("instruction did not finish");

  // ------------------------------------------------------------
  // memory port checks
  // ------------------------------------------------------------
  // write-back must hit the byte just read, address never moves mid-op
  wr_addr_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_MEM_WR |-> ($stable(O_MEM_ADDR) && $past(O_MEM_RD)))
    else $error("write-back address moved");
  wr_mem_only_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_MEM_WR |-> !to_acc)
    else $error("write strobe from accumulator variant");
  rd_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_MEM_RD |=> !O_MEM_RD)
    else $error("read strobe longer than one cycle");
  wr_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_MEM_WR |=> !O_MEM_WR)
    else $error("write strobe longer than one cycle");

  // ------------------------------------------------------------
  // accumulator and flag checks
  // ------------------------------------------------------------
  // only an accumulator variant may load the accumulator
  acc_keep_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    !(O_MEM_RD && to_acc) |=> $stable(O_ACCUMULATOR))
    else $error("accumulator changed by memory variant");
  // status moves only on the edge that closes the read cycle
  status_keep_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    !O_MEM_RD |=> $stable(O_STATUS))
    else $error("status changed outside an instruction");
  // other flags belong to other instructions, so they never move here
  for (genvar b = 0; b < `STATUS_W; b = b + 1) begin : g_flag_keep
    if (b != `ZERO_BIT) begin : g_other
      flag_keep_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
        $stable(O_STATUS[b]))
        else $error("status flag outside zero moved");
    end
  end

  // ------------------------------------------------------------
  // sequencing checks
  // ------------------------------------------------------------
  // done marks the return to idle, so the decoder may issue in that cycle
  done_idle_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_DONE |-> !O_BUSY)
    else $error("done raised while still busy");
  done_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
  // a take reads the addressed byte on the very next cycle
  take_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (I_START && !O_BUSY) |=> (O_BUSY && O_MEM_RD && (O_MEM_ADDR == $past(I_ADDR))))
    else $error("take did not read the addressed byte");
  busy_ignore_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_BUSY |=> $stable(O_MEM_ADDR))
    else $error("address changed while busy");
endmodule
`default_nettype wire

// ---- tb/test_mem_incdec_datapath.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "mem_incdec_defines.svh"
module test_mem_incdec_datapath;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                 ref_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 start   = 1'b0;
  logic [1:0]           op      = 2'h0;
  logic [`ADDR_W-1:0]   addr    = 8'h00;
  logic [`DATA_W-1:0]   rdata   = 8'h00;
  logic                 mem_rd, mem_wr, busy, done;
  logic [`ADDR_W-1:0]   mem_addr;
  logic [`DATA_W-1:0]   mem_wdata, acc, exp_acc;
  logic [`STATUS_W-1:0] status;
  int                   err_total = 0;
  int                   cmp_count = 0;
  int                   cycles    = 0;

  always #10 ref_clk = ~ref_clk;

  mem_incdec_datapath dut (
    .I_REF_CLK(ref_clk), .I_RESET_N(reset_n), .I_START(start), .I_OP(op),
    .I_ADDR(addr), .O_MEM_RD(mem_rd), .O_MEM_WR(mem_wr), .O_MEM_ADDR(mem_addr),
    .O_MEM_WDATA(mem_wdata), .I_MEM_RDATA(rdata), .O_ACCUMULATOR(acc),
    .O_STATUS(status), .O_BUSY(busy), .O_DONE(done));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one instruction; read data is inverted afterwards so a stale bus never matches
  task automatic run_op(input logic [1:0] o, input logic [7:0] a, input logic [7:0] v);
    logic [7:0] res;
    logic [7:0] st;
    res = o[1] ? v + 8'h01 : v - 8'h01;
    st = 8'h00;
    st[`ZERO_BIT] = (res == 8'h00);
    @(posedge ref_clk) #2;
    start = 1'b1; op = o; addr = a; rdata = v;
    @(posedge ref_clk) #2;
    start = 1'b0;
    check(8'(mem_rd), 8'h01);
    check(mem_addr, a);
    @(posedge ref_clk) #2;
    if (!o[0]) begin
      check(8'(mem_wr), 8'h01);
      check(mem_wdata, res);
      check(acc, exp_acc);
      check(mem_addr, a);
      @(posedge ref_clk) #2;
    end else begin
      check(8'(mem_wr), 8'h00);
      check(acc, res);
      exp_acc = res;
    end
    check(8'(done), 8'h01);
    check(8'(busy), 8'h00);
    check(status, st);
    rdata = ~v;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic dec_mem_wrap;
    run_op(mem_incdec_pkg::OP_LONG_DECREMENT_MEMORY, 8'h3C, 8'h00);
    run_op(mem_incdec_pkg::OP_LONG_DECREMENT_MEMORY, 8'h3D, 8'h01);
  endtask

  task automatic dec_acc;
    run_op(mem_incdec_pkg::OP_LONG_DECREMENT_TO_ACCUMULATOR, 8'h80, 8'h01);
    run_op(mem_incdec_pkg::OP_LONG_DECREMENT_TO_ACCUMULATOR, 8'h81, 8'h5A);
  endtask

  task automatic inc_mem_wrap;
    run_op(mem_incdec_pkg::OP_LONG_INCREMENT_MEMORY, 8'hFF, 8'hFF);
    run_op(mem_incdec_pkg::OP_LONG_INCREMENT_MEMORY, 8'h00, 8'h7F);
  endtask

  task automatic inc_acc;
    run_op(mem_incdec_pkg::OP_LONG_INCREMENT_TO_ACCUMULATOR, 8'h10, 8'hFF);
    run_op(mem_incdec_pkg::OP_LONG_INCREMENT_TO_ACCUMULATOR, 8'h11, 8'hFE);
  endtask

  // start held high while busy must not launch a second operation
  task automatic start_while_busy;
    @(posedge ref_clk) #2;
    start = 1'b1; op = 2'h3; addr = 8'h20; rdata = 8'h41;
    @(posedge ref_clk) #2;
    op = 2'h0;
    @(posedge ref_clk) #2;
    start = 1'b0;
    check(acc, 8'h42);
    @(posedge ref_clk) #2;
    check(8'(busy), 8'h00);
    check(8'(mem_rd), 8'h00);
    check(8'(mem_wr), 8'h00);
    exp_acc = 8'h42;
  endtask

  // reset in the read cycle of a write-back must leave nothing half done
  task automatic reset_mid_op;
    @(posedge ref_clk) #2;
    start = 1'b1; op = 2'h0; addr = 8'h55; rdata = 8'h10;
    @(posedge ref_clk) #2;
    start = 1'b0;
    reset_n = 1'b0;
    @(posedge ref_clk) #2;
    check(8'(busy), 8'h00);
    check(8'(mem_rd), 8'h00);
    check(8'(mem_wr), 8'h00);
    check(mem_addr, 8'h00);
    check(mem_wdata, 8'h00);
    check(acc, `ACC_RESET);
    check(status, `STATUS_RESET);
    @(posedge ref_clk) #2;
    reset_n = 1'b1;
    exp_acc = `ACC_RESET;
    @(posedge ref_clk) #2;
    check(8'(done), 8'h00);
    check(8'(mem_wr), 8'h00);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // all scenarios take well under a hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    exp_acc = `ACC_RESET;
    repeat (12) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    dec_mem_wrap();
    dec_acc();
    inc_mem_wrap();
    inc_acc();
    start_while_busy();
    reset_mid_op();
    dec_mem_wrap();
    wrap_up();
  end
endmodule
`default_nettype wire
